// ===== core/ptm_timer.sv
// 10-bit periodic timer with avalon-mm register slave
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "ptm_defs.svh"
// Operation
// - initial-level bit: start level in compare mode, active level in pwm
// - invert bit flips the timer output pins, not in timer/counter or capture mode
// - capture source: 0 capture pin, 1 external clock pin
// - clear select 1 clears on match a, 0 on match p or overflow
// - overflow clearing only when compare_p_value is all zero
// - clear select ignored in pwm, single pulse and capture modes
// - counter read through two read-only bytes, unused high bits zero
// - compare values in low byte plus two high bits, reset zero
// - mode 00 is compare match output mode
// - compare mode, clear select 0: both match flags set
// - compare mode, clear select 1: only match a flag set
// - in compare mode only a match a moves the pin
// - compare action: none, low, high, toggle
// - run bit rising loads the pin with the initial level
// - run rising clears counter, falling holds it
// - mode 11 acts as compare mode without the output pin
// - pwm period by match p clear, duty by compare_a_value
// - pwm sets match a and match p flags
// - pwm action: inactive, active, waveform, single pulse
// - pwm counting continues while the level is forced
// - compare_a_value at or above compare_p_value gives full duty
// - pwm action enables waveform or forces a fixed level
module ptm_timer (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [7:0]        avs_writedata,
  output logic      [7:0]        avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              int_tick,
  input  wire logic              ext_clock_pin,
  input  wire logic              capture_pin,
  output logic                   capture_trigger,
  output ptm_pkg::ptm_count_t    count_value,
  output logic                   timer_out_0,
  output logic                   timer_out_1,
  output logic                   timer_out_en
);
  import ptm_pkg::*;

  logic        counter_run;
  logic        tick_select;
  logic [7:0]  timer_output_control;
  ptm_count_t  compare_a_value;
  ptm_count_t  compare_p_value;
  logic        match_a_flag;
  logic        match_p_flag;
  logic        run_prev;
  logic        ext_prev;
  logic        pin_level;
  logic        pwm_high;
  logic        acc_done;
  logic        tick;
  logic        run_rise;
  logic        match_a;
  logic        match_p;
  logic        clear_cnt;
  logic        level;
  logic        wr_en;
  logic        flag_clr_a;
  logic        flag_clr_p;
  logic        wr_run;
  logic        wr_ctrl;
  logic        wr_a_lo;
  logic        wr_a_hi;
  logic        wr_p_lo;
  logic        wr_p_hi;
  logic        wr_flags;
  logic        out_level;
  logic        drive_en;
  logic [7:0]  next_readdata;
  ptm_mode_t   mode;
  ptm_action_t action;

  assign mode   = ptm_mode_t'(timer_output_control[`PTM_MODE_HI_BIT:`PTM_MODE_LO_BIT]);
  assign action = ptm_action_t'(timer_output_control[`PTM_ACT_HI_BIT:`PTM_ACT_LO_BIT]);

  // one wait cycle per access keeps the read data registered
  assign avs_waitrequest = (avs_read | avs_write) & ~acc_done;
  // a write lands only in the answered cycle, where waitrequest is low
  assign wr_en = avs_write & acc_done;

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_done <= 1'b0;
    end else begin
      acc_done <= (avs_read | avs_write) & ~acc_done;
    end
  end

  // tick source: internal divider enable or external pin rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_clock_pin;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      run_prev <= 1'b0;
    end else begin
      run_prev <= counter_run;
    end
  end
  assign tick     = tick_select ? (ext_clock_pin & ~ext_prev) : int_tick;
  assign run_rise = counter_run & ~run_prev;

  assign capture_trigger = timer_output_control[`PTM_CAPSEL_BIT] ? ext_clock_pin : capture_pin;

  assign match_a = tick & counter_run & (count_value == compare_a_value);
  assign match_p = tick & counter_run & (count_value == compare_p_value);

  always_comb begin
    clear_cnt = 1'b0;
    case (mode)
      PTM_MODE_PWM: begin
        clear_cnt = match_p;
      end
      PTM_MODE_CAP: begin
        clear_cnt = match_p;
      end
      default: begin
        if (timer_output_control[`PTM_CLRSEL_BIT]) begin
          clear_cnt = match_a;
        end else if (compare_p_value == `PTM_CNT_ZERO) begin
          clear_cnt = tick & counter_run & (count_value == `PTM_CNT_MAX);
        end else begin
          clear_cnt = match_p;
        end
      end
    endcase
  end

  // counter
  always_ff @(posedge clk) begin
    if (rst) begin
      count_value <= `PTM_CNT_ZERO;
    end else if (run_rise) begin
      count_value <= `PTM_CNT_ZERO;
    end else if (counter_run & tick) begin
      if (clear_cnt) begin
        count_value <= `PTM_CNT_ZERO;
      end else begin
        count_value <= count_value + `PTM_CNT_ONE;
      end
    end
  end

  // one write strobe per register; unmapped offsets raise none, so such writes drop
  always_comb begin
    wr_run   = 1'b0;
    wr_ctrl  = 1'b0;
    wr_a_lo  = 1'b0;
    wr_a_hi  = 1'b0;
    wr_p_lo  = 1'b0;
    wr_p_hi  = 1'b0;
    wr_flags = 1'b0;
    if (avs_address == `PTM_OFS_RUN_CTRL) begin
      wr_run = wr_en;
    end else if (avs_address == `PTM_OFS_OUT_CTRL) begin
      wr_ctrl = wr_en;
    end else if (avs_address == `PTM_OFS_CMPA_LO) begin
      wr_a_lo = wr_en;
    end else if (avs_address == `PTM_OFS_CMPA_HI) begin
      wr_a_hi = wr_en;
    end else if (avs_address == `PTM_OFS_CMPP_LO) begin
      wr_p_lo = wr_en;
    end else if (avs_address == `PTM_OFS_CMPP_HI) begin
      wr_p_hi = wr_en;
    end else if (avs_address == `PTM_OFS_FLAGS) begin
      wr_flags = wr_en;
    end
  end

  // match flags, set wins over software clear
  assign flag_clr_a = wr_flags & avs_writedata[`PTM_FLAG_A_BIT];
  assign flag_clr_p = wr_flags & avs_writedata[`PTM_FLAG_P_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      match_a_flag <= 1'b0;
    end else if (match_a) begin
      match_a_flag <= 1'b1;
    end else if (flag_clr_a) begin
      match_a_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      match_p_flag <= 1'b0;
    end else if (match_p && !((mode == PTM_MODE_CMP || mode == PTM_MODE_TIMER)
                              && timer_output_control[`PTM_CLRSEL_BIT])) begin
      match_p_flag <= 1'b1;
    end else if (flag_clr_p) begin
      match_p_flag <= 1'b0;
    end
  end

  // compare output level
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_level <= 1'b0;
    end else if (run_rise) begin
      pin_level <= timer_output_control[`PTM_INIT_BIT];
    end else if (match_a && mode == PTM_MODE_CMP) begin
      case (action)
        PTM_ACT_A1: pin_level <= 1'b0;
        PTM_ACT_A2: pin_level <= 1'b1;
        PTM_ACT_A3: pin_level <= ~pin_level;
        default:    pin_level <= pin_level;
      endcase
    end
  end

  // pwm active phase: from period start until duty match
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_high <= 1'b0;
    end else if (run_rise) begin
      pwm_high <= 1'b1;
    end else if (counter_run & tick) begin
      if (compare_a_value >= compare_p_value) begin
        pwm_high <= 1'b1;
      end else if (clear_cnt) begin
        pwm_high <= 1'b1;
      end else if (match_a) begin
        pwm_high <= 1'b0;
      end
    end
  end

  always_comb begin
    level = 1'b0;
    case (mode)
      PTM_MODE_PWM: begin
        case (action)
          PTM_ACT_A0: level = ~timer_output_control[`PTM_INIT_BIT];
          PTM_ACT_A1: level = timer_output_control[`PTM_INIT_BIT];
          // single pulse: active while running, not modelled further
          PTM_ACT_A3: level = counter_run ? timer_output_control[`PTM_INIT_BIT]
                                          : ~timer_output_control[`PTM_INIT_BIT];
          default:    level = pwm_high ? timer_output_control[`PTM_INIT_BIT]
                                       : ~timer_output_control[`PTM_INIT_BIT];
        endcase
      end
      PTM_MODE_CMP: level = pin_level;
      default:      level = 1'b0;
    endcase
  end

  // invert last; timer/counter and capture modes hold the pins low, so the
  // invert bit cannot show through there
  assign out_level = drive_en ? (level ^ timer_output_control[`PTM_INV_BIT]) : 1'b0;
  assign drive_en  = (mode == PTM_MODE_CMP) || (mode == PTM_MODE_PWM);

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_out_0 <= 1'b0;
    end else begin
      timer_out_0 <= out_level;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_out_1 <= 1'b0;
    end else begin
      timer_out_1 <= out_level;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_out_en <= 1'b0;
    end else begin
      timer_out_en <= drive_en;
    end
  end

  // register writes, one process per register
  always_ff @(posedge clk) begin
    if (rst) begin
      counter_run <= 1'b0;
      tick_select <= 1'b0;
    end else if (wr_run) begin
      counter_run <= avs_writedata[`PTM_RUN_BIT];
      tick_select <= avs_writedata[`PTM_TICK_SEL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_output_control <= `PTM_CTRL_RESET;
    end else if (wr_ctrl) begin
      timer_output_control <= avs_writedata;
    end
  end

  // halves load independently; the comparators see a mixed value between the two writes
  always_ff @(posedge clk) begin
    if (rst) begin
      compare_a_value[7:0] <= 8'h00;
    end else if (wr_a_lo) begin
      compare_a_value[7:0] <= avs_writedata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      compare_a_value[9:8] <= 2'b00;
    end else if (wr_a_hi) begin
      compare_a_value[9:8] <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      compare_p_value[7:0] <= 8'h00;
    end else if (wr_p_lo) begin
      compare_p_value[7:0] <= avs_writedata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      compare_p_value[9:8] <= 2'b00;
    end else if (wr_p_hi) begin
      compare_p_value[9:8] <= avs_writedata[1:0];
    end
  end

  // register reads; unmapped offsets read zero
  always_comb begin
    next_readdata = 8'h00;
    if (avs_address == `PTM_OFS_RUN_CTRL) begin
      next_readdata = {6'h00, tick_select, counter_run};
    end else if (avs_address == `PTM_OFS_OUT_CTRL) begin
      next_readdata = timer_output_control;
    end else if (avs_address == `PTM_OFS_CNT_LO) begin
      next_readdata = count_value[7:0];
    end else if (avs_address == `PTM_OFS_CNT_HI) begin
      next_readdata = {6'h00, count_value[9:8]};
    end else if (avs_address == `PTM_OFS_CMPA_LO) begin
      next_readdata = compare_a_value[7:0];
    end else if (avs_address == `PTM_OFS_CMPA_HI) begin
      next_readdata = {6'h00, compare_a_value[9:8]};
    end else if (avs_address == `PTM_OFS_CMPP_LO) begin
      next_readdata = compare_p_value[7:0];
    end else if (avs_address == `PTM_OFS_CMPP_HI) begin
      next_readdata = {6'h00, compare_p_value[9:8]};
    end else if (avs_address == `PTM_OFS_FLAGS) begin
      next_readdata = {6'h00, match_p_flag, match_a_flag};
    end
  end

  // read data is latched in the wait cycle and stands until the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 8'h00;
    end else if (avs_read & ~acc_done) begin
      avs_readdata <= next_readdata;
    end
  end
endmodule

// ===== include/ptm_defs.svh
// offsets, field positions, reset values and counts for the periodic timer
`ifndef PTM_DEFS_SVH
`define PTM_DEFS_SVH

`define PTM_OFS_RUN_CTRL      4'h0
`define PTM_OFS_OUT_CTRL      4'h1
`define PTM_OFS_CNT_LO        4'h2
`define PTM_OFS_CNT_HI        4'h3
`define PTM_OFS_CMPA_LO       4'h4
`define PTM_OFS_CMPA_HI       4'h5
`define PTM_OFS_CMPP_LO       4'h6
`define PTM_OFS_CMPP_HI       4'h7
`define PTM_OFS_FLAGS         4'h8

`define PTM_RUN_BIT           0
`define PTM_TICK_SEL_BIT      1
`define PTM_MODE_HI_BIT       7
`define PTM_MODE_LO_BIT       6
`define PTM_ACT_HI_BIT        5
`define PTM_ACT_LO_BIT        4
`define PTM_INIT_BIT          3
`define PTM_INV_BIT           2
`define PTM_CAPSEL_BIT        1
`define PTM_CLRSEL_BIT        0
`define PTM_FLAG_A_BIT        0
`define PTM_FLAG_P_BIT        1

`define PTM_CTRL_RESET        8'h00
`define PTM_CNT_W             10
`define PTM_CNT_ZERO          10'h000
`define PTM_CNT_ONE           10'h001
`define PTM_CNT_MAX           10'h3FF

`endif

// ===== include/ptm_pkg.sv
// types for the periodic timer
package ptm_pkg;
  typedef enum logic [1:0] {
    PTM_MODE_CMP   = 2'b00,
    PTM_MODE_CAP   = 2'b01,
    PTM_MODE_PWM   = 2'b10,
    PTM_MODE_TIMER = 2'b11
  } ptm_mode_t;

  typedef enum logic [1:0] {
    PTM_ACT_A0 = 2'b00,
    PTM_ACT_A1 = 2'b01,
    PTM_ACT_A2 = 2'b10,
    PTM_ACT_A3 = 2'b11
  } ptm_action_t;

  typedef logic [9:0] ptm_count_t;
endpackage

// ===== test/ptm_timer_assertions.sv
// port-level checker for the periodic timer
`timescale 1ns/1ps
`include "ptm_defs.svh"
module ptm_timer_checker (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic [3:0]          avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [7:0]          avs_writedata,
  input wire logic [7:0]          avs_readdata,
  input wire logic                avs_waitrequest,
  input wire logic                ext_clock_pin,
  input wire logic                capture_pin,
  input wire logic                capture_trigger,
  input wire ptm_pkg::ptm_count_t count_value,
  input wire logic                timer_out_0,
  input wire logic                timer_out_1,
  input wire logic                timer_out_en
);
  import ptm_pkg::*;
  // shadow copies of control state, updated at the edge a write takes effect
  logic [7:0] ctrl;
  logic       run;
  wire        wr_done = avs_write && !avs_waitrequest;
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= `PTM_CTRL_RESET;
      run  <= 1'b0;
    end else if (wr_done && avs_address == `PTM_OFS_OUT_CTRL) begin
      ctrl <= avs_writedata;
    end else if (wr_done && avs_address == `PTM_OFS_RUN_CTRL) begin
      run <= avs_writedata[`PTM_RUN_BIT];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req_open;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // three edges give the registered pin logic time to follow a mode change
  sequence s_mode_held;
    $stable(ctrl[7:6]) [*3];
  endsequence
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait state");
  a_wait_one: assert property (s_req_open |=> !avs_waitrequest) else $error("wait state too long");
  a_capsel_route: assert property (capture_trigger == (ctrl[1] ? ext_clock_pin : capture_pin))
    else $error("capture source wrong");
  a_pins_equal: assert property (timer_out_0 == timer_out_1) else $error("output pins differ");
  a_timer_pin_off: assert property (s_mode_held ##0 ctrl[7:6] == 2'b11 |-> !timer_out_en && !timer_out_0)
    else $error("pin used in timer mode");
  a_en_modes: assert property (s_mode_held |-> timer_out_en == !ctrl[6]) else $error("pin enable wrong");
  a_count_hold: assert property (!run [*3] |-> $stable(count_value)) else $error("count moved while off");
  a_count_step: assert property (count_value != $past(count_value) |->
    count_value == $past(count_value) + 10'h001 || count_value == `PTM_CNT_ZERO) else $error("count jumped");
  a_hi_zero: assert property (avs_read && !avs_waitrequest && avs_address inside {4'h3, 4'h5, 4'h7} |->
    avs_readdata[7:2] == 6'h00) else $error("high byte unused bits set");
endmodule
bind ptm_timer ptm_timer_checker chk_u (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .ext_clock_pin, .capture_pin, .capture_trigger, .count_value,
  .timer_out_0, .timer_out_1, .timer_out_en);

// ===== test/tb_top.sv
// self-checking bench for the periodic timer
`timescale 1ns/1ps
`include "ptm_defs.svh"
module tb_top;
  import ptm_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [7:0] avs_writedata = 8'h00, avs_readdata, rd_val;
  logic       int_tick = 1'b0, ext_clock_pin = 1'b0, capture_pin = 1'b0;
  logic       avs_waitrequest, capture_trigger, timer_out_0, timer_out_1, timer_out_en;
  ptm_count_t count_value;
  int         n_fail = 0;
  int         samples_checked = 0;
  always #25 clk = ~clk;
  ptm_timer dut_u (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .int_tick, .ext_clock_pin, .capture_pin, .capture_trigger, .count_value,
    .timer_out_0, .timer_out_1, .timer_out_en);
  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
    logic w;
    int   n;
    w = 1'b1;
    n = 0;
    @(posedge clk);
    {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
    while (w && n < 20) begin
      @(posedge clk);
      w = (avs_waitrequest !== 1'b0);
      rd_val = avs_readdata;
      n++;
    end
    {avs_write, avs_read} <= 2'b00;
    if (w) begin
      chk("waitrequest", 16'h0, 16'h1);
      complete_run();
    end
  endtask
  task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(what, e, rd_val);
  endtask
  task automatic ticks(input int n);
    @(posedge clk);
    int_tick <= 1'b1;
    repeat (n) @(posedge clk);
    int_tick <= 1'b0;
    @(posedge clk);
  endtask
  // pin register follows the tick edge, the output one edge later
  task automatic pin(input logic e);
    repeat (2) @(posedge clk);
    chk("timer_out_0", e, timer_out_0);
  endtask
  task automatic cmp(input logic [9:0] a, input logic [9:0] p);
    acc(1'b1, `PTM_OFS_CMPA_LO, a[7:0]);
    acc(1'b1, `PTM_OFS_CMPA_HI, {6'h00, a[9:8]});
    acc(1'b1, `PTM_OFS_CMPP_LO, p[7:0]);
    acc(1'b1, `PTM_OFS_CMPP_HI, {6'h00, p[9:8]});
  endtask
  task automatic start(input logic [7:0] c);
    acc(1'b1, `PTM_OFS_RUN_CTRL, 8'h00);
    acc(1'b1, `PTM_OFS_FLAGS, 8'h03);
    acc(1'b1, `PTM_OFS_OUT_CTRL, c);
    acc(1'b1, `PTM_OFS_RUN_CTRL, 8'h01);
    repeat (3) @(posedge clk);
  endtask
  initial begin
    logic [1:0] a;
    logic       ini;
    logic       ex;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rdc("reset value", i[3:0], 8'h00);
    acc(1'b1, `PTM_OFS_CMPA_HI, 8'hFF);
    rdc("compare a high", `PTM_OFS_CMPA_HI, 8'h03);
    acc(1'b1, `PTM_OFS_CNT_LO, 8'h55);
    rdc("count low", `PTM_OFS_CNT_LO, 8'h00);
    acc(1'b1, 4'h9, 8'hAA);
    rdc("unmapped", 4'h9, 8'h00);
    {ext_clock_pin, capture_pin} <= 2'b10;
    for (int s = 0; s < 2; s++) begin
      acc(1'b1, `PTM_OFS_OUT_CTRL, {6'h00, s[0], 1'b0});
      @(posedge clk);
      chk("capture_trigger", {15'h0000, s[0]}, capture_trigger);
    end
    cmp(10'h003, 10'h005);
    for (int i = 0; i < 8; i++) begin
      a = i[1:0];
      ini = (a != 2'b10);
      ex = (a == 2'b00) ? ini : (a == 2'b01) ? 1'b0 : (a == 2'b10) ? 1'b1 : !ini;
      start({2'b00, a, ini, i[2], 2'b00});
      pin(ini ^ i[2]);
      ticks(4);
      pin(ex ^ i[2]);
      ticks(2);
      chk("count", 16'h0, count_value);
      rdc("flags", `PTM_OFS_FLAGS, 8'h03);
      pin(ex ^ i[2]);
    end
    cmp(10'h003, 10'h001);
    for (int m = 0; m < 4; m += 3) begin
      start({m[1:0], 6'b110101});
      ticks(4);
      chk("count", 16'h0, count_value);
      rdc("flags", `PTM_OFS_FLAGS, 8'h01);
      chk("timer_out_en", m == 0, timer_out_en);
      if (m == 3) begin
        chk("timer_out_0", 16'h0, timer_out_0);
      end
    end
    cmp(10'h200, 10'h000);
    start(8'h00);
    ticks(1023);
    rdc("count low", `PTM_OFS_CNT_LO, 8'hFF);
    rdc("count high", `PTM_OFS_CNT_HI, 8'h03);
    ticks(1);
    chk("count", 16'h0, count_value);
    cmp(10'h002, 10'h005);
    start(8'hA8);
    pin(1'b1);
    ticks(3);
    pin(1'b0);
    ticks(3);
    pin(1'b1);
    chk("count", 16'h0, count_value);
    rdc("flags", `PTM_OFS_FLAGS, 8'h03);
    for (int f = 0; f < 2; f++) begin
      start({3'b100, f[0], 4'b1000});
      ticks(3);
      pin(f[0]);
      chk("count", 16'h3, count_value);
    end
    start(8'hA8);
    ticks(3);
    pin(1'b0);
    cmp(10'h006, 10'h005);
    for (int k = 0; k < 12; k++) begin
      ticks(1);
      pin(1'b1);
    end
    acc(1'b1, `PTM_OFS_RUN_CTRL, 8'h00);
    acc(1'b1, `PTM_OFS_RUN_CTRL, 8'h03);
    for (int e = 0; e < 6; e++) begin
      @(posedge clk);
      ext_clock_pin <= e[0];
    end
    repeat (2) @(posedge clk);
    chk("count", 16'h3, count_value);
    complete_run();
  end
endmodule
